/* File: rtl/flic_pkg.sv */
// Shared constants, source tables and state types of the four-level interrupt controller.
package flic_pkg;

    // Counts and widths.
    localparam int unsigned NUM_SRC  = 15;
    localparam int unsigned NUM_FLAG = 17;
    localparam int unsigned NUM_PIN  = 6;
    localparam int unsigned NUM_LVL  = 4;
    localparam int unsigned NUM_CMP  = 3;
    localparam int unsigned NUM_CAP  = 4;
    localparam int unsigned LVL_W    = 2;
    localparam int unsigned SRC_W    = 4;
    localparam int unsigned VEC_W    = 16;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned CODE_W   = 5;

    // Flag indices in the flag bank.
    localparam int unsigned F_EXT0    = 0;
    localparam int unsigned F_EXT1    = 1;
    localparam int unsigned F_CAP0    = 2;
    localparam int unsigned F_CMP0    = 6;
    localparam int unsigned F_T0      = 9;
    localparam int unsigned F_T1      = 10;
    localparam int unsigned F_URX     = 11;
    localparam int unsigned F_UTX     = 12;
    localparam int unsigned F_I2C     = 13;
    localparam int unsigned F_ADC     = 14;
    localparam int unsigned F_BYTE_OV = 15;
    localparam int unsigned F_WORD_OV = 16;

    // Pin indices in the synchroniser chain.
    localparam int unsigned P_EXT0 = 0;
    localparam int unsigned P_EXT1 = 1;
    localparam int unsigned P_CAP0 = 2;

    // Source indices in tie order, zero is served first within a level.
    localparam int unsigned S_EXT0 = 0;
    localparam int unsigned S_I2C  = 1;
    localparam int unsigned S_ADC  = 2;
    localparam int unsigned S_T0   = 3;
    localparam int unsigned S_CAP0 = 4;
    localparam int unsigned S_CMP0 = 5;
    localparam int unsigned S_EXT1 = 6;
    localparam int unsigned S_CAP1 = 7;
    localparam int unsigned S_CMP1 = 8;
    localparam int unsigned S_T1   = 9;
    localparam int unsigned S_CAP2 = 10;
    localparam int unsigned S_CMP2 = 11;
    localparam int unsigned S_UART = 12;
    localparam int unsigned S_CAP3 = 13;
    localparam int unsigned S_WORD_OVERFLOW_FLAG = 14;

    // Vector address of each source, indexed by source number.
    localparam logic [NUM_SRC-1:0][VEC_W-1:0] VECTOR_TABLE = {
        16'h0073, 16'h004b, 16'h0023, 16'h006b, 16'h0043,
        16'h001b, 16'h0063, 16'h003b, 16'h0013, 16'h005b,
        16'h0033, 16'h000b, 16'h0053, 16'h002b, 16'h0003
    };

    // Enable register layout.
    localparam int unsigned GLOBAL_EN_BIT = 7;

    // Counter wrap detection values.
    localparam logic [7:0]       BYTE_MAX  = 8'hff;
    localparam logic [7:0]       BYTE_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] WORD_MAX  = 16'hffff;
    localparam logic [CNT_W-1:0] WORD_ZERO = 16'h0000;

    // Two-wire status code that carries no bus state and raises no request.
    localparam logic [CODE_W-1:0] I2C_IDLE_CODE = 5'h1f;

    // Software may not set the converter-done flag.
    localparam logic [NUM_FLAG-1:0] SW_SET_MASK = 17'h1bfff;

    // Reset values.
    localparam logic [NUM_PIN-1:0]  PIN_RESET = 6'h00;
    localparam logic [NUM_LVL-1:0]  ISR_RESET = 4'h0;
    localparam logic [NUM_FLAG-1:0] FLAG_RESET = 17'h00000;

    // Request presented to the CPU core.
    typedef struct packed {
        logic             req;
        logic [LVL_W-1:0] level;
        logic [SRC_W-1:0] source;
        logic [VEC_W-1:0] vector;
    } flic_present_s;

    // State of the controller top; the flags are held in the flag bank.
    typedef struct packed {
        logic [NUM_PIN-1:0] pin_meta;
        logic [NUM_PIN-1:0] pin_sync;
        logic [NUM_PIN-1:0] pin_prev;
        logic [CNT_W-1:0]   prev_cnt;
        logic [NUM_LVL-1:0] in_service;
        flic_present_s      present;
    } flic_state_s;

endpackage

/* File: rtl/flic_flag.sv */
// Bank of sticky interrupt flags with hardware set and software set and clear.
`timescale 1ns/1ps
module flic_flag #(
    parameter int unsigned W             = 17,
    parameter logic [W-1:0] SET_MASK     = '1,
    parameter logic [W-1:0] RESET_VALUE  = '0
) (
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] hw_set_i,
    input  wire logic [W-1:0] sw_set_i,
    input  wire logic [W-1:0] sw_clr_i,
    output logic      [W-1:0] flag_o
);

    logic [W-1:0] flag;
    logic [W-1:0] next_flag;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        next_flag = (flag & ~sw_clr_i) | hw_set_i | (sw_set_i & SET_MASK);
    end

    // Flags hold until cleared; hardware never clears them.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag <= RESET_VALUE;
        end else begin
            flag <= next_flag;
        end
    end

    assign flag_o = flag;

endmodule // flic_flag

/* File: rtl/flic_pick.sv */
// Picks the highest-level pending source, lowest source number winning ties.
`timescale 1ns/1ps
module flic_pick (
    input  wire logic [flic_pkg::NUM_SRC-1:0]                     req_i,
    input  wire logic [flic_pkg::NUM_SRC-1:0][flic_pkg::LVL_W-1:0] lvl_i,
    output logic                                                  valid_o,
    output logic      [flic_pkg::SRC_W-1:0]                       src_o,
    output logic      [flic_pkg::LVL_W-1:0]                       lvl_o
);

    // Scan from the last source down; equal level replaces, so earlier sources win.
    always_comb begin
        valid_o = 1'b0;
        src_o   = '0;
        lvl_o   = '0;
        for (int i = flic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req_i[i] && (!valid_o || lvl_i[i] >= lvl_o)) begin
                valid_o = 1'b1;
                src_o   = flic_pkg::SRC_W'(i);
                lvl_o   = lvl_i[i];
            end
        end
    end

endmodule // flic_pick

/* File: rtl/flic_top.sv */
// Four-level nested interrupt controller with fifteen vectored sources.
`timescale 1ns/1ps
module flic_top (
    input  wire logic                                             clk_sys_i,
    input  wire logic                                             arst_n_i,
    input  wire logic                                             external_irq0_n_i,
    input  wire logic                                             external_irq1_n_i,
    input  wire logic [flic_pkg::NUM_CAP-1:0]                     capture_input_i,
    input  wire logic                                             timer0_overflow_i,
    input  wire logic                                             timer1_overflow_i,
    input  wire logic                                             uart_rx_done_i,
    input  wire logic                                             uart_tx_done_i,
    input  wire logic                                             serial_bus_status_load_i,
    input  wire logic [flic_pkg::CODE_W-1:0]                      serial_bus_status_code_i,
    input  wire logic                                             adc_result_ready_i,
    input  wire logic [flic_pkg::CNT_W-1:0]                       capture_timer_count_i,
    input  wire logic [flic_pkg::NUM_CMP-1:0][flic_pkg::CNT_W-1:0] compare_value_i,
    input  wire logic [7:0]                                       irq_enable_reg_a_i,
    input  wire logic [7:0]                                       irq_enable_reg_b_i,
    input  wire logic [7:0]                                       priority_low_reg_a_i,
    input  wire logic [7:0]                                       priority_low_reg_b_i,
    input  wire logic [7:0]                                       priority_high_reg_a_i,
    input  wire logic [7:0]                                       priority_high_reg_b_i,
    input  wire logic [flic_pkg::NUM_FLAG-1:0]                    flag_sw_set_i,
    input  wire logic [flic_pkg::NUM_FLAG-1:0]                    flag_sw_clr_i,
    input  wire logic                                             irq_ack_i,
    input  wire logic                                             irq_return_i,
    output logic                                                  irq_req_o,
    output logic      [flic_pkg::VEC_W-1:0]                       irq_vector_o,
    output logic      [flic_pkg::LVL_W-1:0]                       irq_level_o,
    output logic      [flic_pkg::SRC_W-1:0]                       irq_source_o,
    output logic      [flic_pkg::NUM_LVL-1:0]                     in_service_o,
    output logic      [flic_pkg::NUM_FLAG-1:0]                    flags_o
);

    flic_pkg::flic_state_s                          st;
    flic_pkg::flic_state_s                          next_st;
    logic [flic_pkg::NUM_PIN-1:0]                   pins;
    logic [flic_pkg::NUM_FLAG-1:0]                  hw_set;
    logic [flic_pkg::NUM_FLAG-1:0]                  flags;
    logic [flic_pkg::NUM_SRC-1:0]                   src_flag;
    logic [flic_pkg::NUM_SRC-1:0]                   src_en;
    logic [flic_pkg::NUM_SRC-1:0]                   src_plo;
    logic [flic_pkg::NUM_SRC-1:0]                   src_phi;
    logic [flic_pkg::NUM_SRC-1:0]                   pending;
    logic [flic_pkg::NUM_SRC-1:0][flic_pkg::LVL_W-1:0] src_lvl;
    logic                                           best_valid;
    logic [flic_pkg::SRC_W-1:0]                     best_src;
    logic [flic_pkg::LVL_W-1:0]                     best_lvl;
    logic                                           cnt_moved;
    logic                                           global_en;

    // Spreads the two register halves over the sources in tie order.
    function automatic logic [flic_pkg::NUM_SRC-1:0] by_source(
        input logic [7:0] reg_a,
        input logic [7:0] reg_b
    );
        logic [flic_pkg::NUM_SRC-1:0] v;
        v = '0;
        v[flic_pkg::S_EXT0] = reg_a[0];
        v[flic_pkg::S_T0]   = reg_a[1];
        v[flic_pkg::S_EXT1] = reg_a[2];
        v[flic_pkg::S_T1]   = reg_a[3];
        v[flic_pkg::S_UART] = reg_a[4];
        v[flic_pkg::S_I2C]  = reg_a[5];
        v[flic_pkg::S_ADC]  = reg_a[6];
        v[flic_pkg::S_CAP0] = reg_b[0];
        v[flic_pkg::S_CAP1] = reg_b[1];
        v[flic_pkg::S_CAP2] = reg_b[2];
        v[flic_pkg::S_CAP3] = reg_b[3];
        v[flic_pkg::S_CMP0] = reg_b[4];
        v[flic_pkg::S_CMP1] = reg_b[5];
        v[flic_pkg::S_CMP2] = reg_b[6];
        v[flic_pkg::S_WORD_OVERFLOW_FLAG] = reg_b[7];
        return v;
    endfunction

    // Clears the highest level bit that is in service.
    function automatic logic [flic_pkg::NUM_LVL-1:0] drop_top(
        input logic [flic_pkg::NUM_LVL-1:0] isr
    );
        logic [flic_pkg::NUM_LVL-1:0] v;
        logic                         done;
        v    = isr;
        done = 1'b0;
        for (int i = flic_pkg::NUM_LVL - 1; i >= 0; i--) begin
            if (v[i] && !done) begin
                v[i] = 1'b0;
                done = 1'b1;
            end
        end
        return v;
    endfunction

    // Pin inputs gathered for the synchroniser chain.
    assign pins = {capture_input_i, ~external_irq1_n_i, ~external_irq0_n_i};

    // Flag set events from pins, peer units and the capture timer count.
    always_comb begin
        hw_set    = '0;
        cnt_moved = capture_timer_count_i != st.prev_cnt;
        // External lines request on a falling edge, seen after synchronising.
        hw_set[flic_pkg::F_EXT0] = st.pin_sync[flic_pkg::P_EXT0] & ~st.pin_prev[flic_pkg::P_EXT0];
        hw_set[flic_pkg::F_EXT1] = st.pin_sync[flic_pkg::P_EXT1] & ~st.pin_prev[flic_pkg::P_EXT1];
        for (int i = 0; i < flic_pkg::NUM_CAP; i++) begin
            hw_set[flic_pkg::F_CAP0 + i] = st.pin_sync[flic_pkg::P_CAP0 + i]
                                         & ~st.pin_prev[flic_pkg::P_CAP0 + i];
        end
        for (int i = 0; i < flic_pkg::NUM_CMP; i++) begin
            hw_set[flic_pkg::F_CMP0 + i] = cnt_moved
                                         && capture_timer_count_i == compare_value_i[i];
        end
        hw_set[flic_pkg::F_BYTE_OV] = st.prev_cnt[7:0] == flic_pkg::BYTE_MAX
                                    && capture_timer_count_i[7:0] == flic_pkg::BYTE_ZERO;
        hw_set[flic_pkg::F_WORD_OV] = st.prev_cnt == flic_pkg::WORD_MAX
                                    && capture_timer_count_i == flic_pkg::WORD_ZERO;
        hw_set[flic_pkg::F_T0]  = timer0_overflow_i;
        hw_set[flic_pkg::F_T1]  = timer1_overflow_i;
        hw_set[flic_pkg::F_URX] = uart_rx_done_i;
        hw_set[flic_pkg::F_UTX] = uart_tx_done_i;
        hw_set[flic_pkg::F_I2C] = serial_bus_status_load_i
                                && serial_bus_status_code_i != flic_pkg::I2C_IDLE_CODE;
        hw_set[flic_pkg::F_ADC] = adc_result_ready_i;
    end

    // Sticky flag bank; software set of the converter flag is masked off.
    flic_flag #(
        .W           (flic_pkg::NUM_FLAG),
        .SET_MASK    (flic_pkg::SW_SET_MASK),
        .RESET_VALUE (flic_pkg::FLAG_RESET)
    ) u_flags (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .hw_set_i  (hw_set),
        .sw_set_i  (flag_sw_set_i),
        .sw_clr_i  (flag_sw_clr_i),
        .flag_o    (flags)
    );

    // Source requests, enables and levels in tie order.
    always_comb begin
        src_flag = '0;
        src_flag[flic_pkg::S_EXT0] = flags[flic_pkg::F_EXT0];
        src_flag[flic_pkg::S_EXT1] = flags[flic_pkg::F_EXT1];
        src_flag[flic_pkg::S_T0]   = flags[flic_pkg::F_T0];
        src_flag[flic_pkg::S_T1]   = flags[flic_pkg::F_T1];
        src_flag[flic_pkg::S_UART] = flags[flic_pkg::F_URX] | flags[flic_pkg::F_UTX];
        src_flag[flic_pkg::S_I2C]  = flags[flic_pkg::F_I2C];
        src_flag[flic_pkg::S_ADC]  = flags[flic_pkg::F_ADC];
        src_flag[flic_pkg::S_CAP0] = flags[flic_pkg::F_CAP0];
        src_flag[flic_pkg::S_CAP1] = flags[flic_pkg::F_CAP0 + 1];
        src_flag[flic_pkg::S_CAP2] = flags[flic_pkg::F_CAP0 + 2];
        src_flag[flic_pkg::S_CAP3] = flags[flic_pkg::F_CAP0 + 3];
        src_flag[flic_pkg::S_CMP0] = flags[flic_pkg::F_CMP0];
        src_flag[flic_pkg::S_CMP1] = flags[flic_pkg::F_CMP0 + 1];
        src_flag[flic_pkg::S_CMP2] = flags[flic_pkg::F_CMP0 + 2];
        src_flag[flic_pkg::S_WORD_OVERFLOW_FLAG] = flags[flic_pkg::F_BYTE_OV]
                                   | flags[flic_pkg::F_WORD_OV];
        global_en = irq_enable_reg_a_i[flic_pkg::GLOBAL_EN_BIT];
        src_en    = by_source(irq_enable_reg_a_i, irq_enable_reg_b_i);
        src_plo   = by_source(priority_low_reg_a_i, priority_low_reg_b_i);
        src_phi   = by_source(priority_high_reg_a_i, priority_high_reg_b_i);
        for (int i = 0; i < flic_pkg::NUM_SRC; i++) begin
            src_lvl[i] = {src_phi[i], src_plo[i]};
        end
        pending = src_flag & src_en & {flic_pkg::NUM_SRC{global_en}};
    end

    // Best pending request by level, then by fixed order.
    flic_pick u_pick (
        .req_i   (pending),
        .lvl_i   (src_lvl),
        .valid_o (best_valid),
        .src_o   (best_src),
        .lvl_o   (best_lvl)
    );

    // Next state: synchronisers, count history, nesting and presentation.
    always_comb begin
        next_st          = st;
        next_st.pin_meta = pins;
        next_st.pin_sync = st.pin_meta;
        next_st.pin_prev = st.pin_sync;
        next_st.prev_cnt = capture_timer_count_i;
        // A return ends the innermost, highest-level service first.
        if (irq_return_i) begin
            next_st.in_service = drop_top(st.in_service);
        end
        // The CPU takes the presented request; its level enters service.
        if (irq_ack_i && st.present.req) begin
            next_st.in_service[st.present.level] = 1'b1;
        end
        // Only a level above every level in service is presented.
        next_st.present.req    = best_valid
                               && (next_st.in_service >> best_lvl) == flic_pkg::ISR_RESET;
        next_st.present.level  = best_lvl;
        next_st.present.source = best_src;
        next_st.present.vector = flic_pkg::VECTOR_TABLE[best_src];
    end

    // State register.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st.pin_meta   <= flic_pkg::PIN_RESET;
            st.pin_sync   <= flic_pkg::PIN_RESET;
            st.pin_prev   <= flic_pkg::PIN_RESET;
            st.prev_cnt   <= flic_pkg::WORD_ZERO;
            st.in_service <= flic_pkg::ISR_RESET;
            st.present    <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flip-flops.
    assign irq_req_o    = st.present.req;
    assign irq_vector_o = st.present.vector;
    assign irq_level_o  = st.present.level;
    assign irq_source_o = st.present.source;
    assign in_service_o = st.in_service;
    assign flags_o      = flags;

    // With global enable low, nothing is presented in the next cycle.
    AST_GLOBAL_OFF: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !irq_enable_reg_a_i[flic_pkg::GLOBAL_EN_BIT] |=> !irq_req_o)
        else $error("request presented while globally disabled");

    // Software cannot raise the converter-done flag.
    AST_ADC_NO_SW_SET: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (!flags[flic_pkg::F_ADC] && !adc_result_ready_i && flag_sw_set_i[flic_pkg::F_ADC])
        |=> !flags[flic_pkg::F_ADC])
        else $error("converter-done flag set by software");

    // Capture flag 0 stays set until software clears it.
    AST_CAP_HOLD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (flags[flic_pkg::F_CAP0] && !flag_sw_clr_i[flic_pkg::F_CAP0])
        |=> flags[flic_pkg::F_CAP0])
        else $error("capture flag dropped without software clear");

    // A hardware set beats a software clear in the same cycle.
    AST_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (hw_set[flic_pkg::F_T0] && flag_sw_clr_i[flic_pkg::F_T0])
        |=> flags[flic_pkg::F_T0])
        else $error("set lost against clear");

    // A presented request is above every level in service.
    AST_NEST_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        irq_req_o |-> (in_service_o >> irq_level_o) == flic_pkg::ISR_RESET)
        else $error("request presented at or below a level in service");

    // Taking a request places its level in service one cycle later.
    AST_ACK_SERVICE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (irq_req_o && irq_ack_i && !irq_return_i)
        |=> in_service_o[$past(irq_level_o)] && !irq_req_o || irq_level_o > $past(irq_level_o))
        else $error("acknowledged level not in service");

    // A return without a new grant always removes the highest level in service.
    AST_RETURN_DROP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (irq_return_i && !irq_ack_i && in_service_o != flic_pkg::ISR_RESET)
        |=> in_service_o < $past(in_service_o))
        else $error("return left the service levels unchanged");

    // A full 16-bit wrap raises the word overflow flag.
    AST_WORD_OV: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (st.prev_cnt == flic_pkg::WORD_MAX && capture_timer_count_i == flic_pkg::WORD_ZERO)
        |=> flags[flic_pkg::F_WORD_OV] && flags[flic_pkg::F_BYTE_OV])
        else $error("wrap did not set overflow flags");

    // Either overflow flag raises the single capture timer overflow request.
    AST_OVF_PAIR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (flags[flic_pkg::F_BYTE_OV] || flags[flic_pkg::F_WORD_OV])
        |-> src_flag[flic_pkg::S_WORD_OVERFLOW_FLAG])
        else $error("overflow flag raised no request");

    // Either UART completion flag raises the single UART request.
    AST_UART_PAIR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (flags[flic_pkg::F_URX] || flags[flic_pkg::F_UTX])
        |-> src_flag[flic_pkg::S_UART])
        else $error("UART completion flag raised no request");

    // A new count equal to compare value 0 raises its match flag.
    AST_CMP_MATCH: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (cnt_moved && capture_timer_count_i == compare_value_i[0])
        |=> flags[flic_pkg::F_CMP0])
        else $error("compare match did not set its flag");

    // The vector always belongs to the presented source.
    AST_VECTOR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        irq_req_o |-> irq_vector_o == flic_pkg::VECTOR_TABLE[irq_source_o])
        else $error("vector does not match source");

endmodule // flic_top

/* File: bench/flic_cpu_model.sv */
// Behavioural CPU core that serves vectored requests with nested services.
`timescale 1ns/1ps
module flic_cpu_model (
    input  wire logic        clk_sys_i,
    input  wire logic        irq_req_i,
    input  wire logic [3:0]  src_i,
    output logic             ack_o = 1'b0,
    output logic             ret_o = 1'b0,
    output logic      [16:0] clr_o = 17'h0
);
    localparam int FIDX [15] = '{0, 13, 14, 9, 2, 6, 1, 3, 7, 10, 4, 8, 11, 5, 16};
    int depth = 0;
    int timer = 0;
    // Takes a request at once and clears its flags, then returns after a slow service.
    always @(negedge clk_sys_i) begin
        {ack_o, ret_o, clr_o} <= '0;
        timer <= irq_req_i ? 25 : timer - 1;
        if (irq_req_i) begin
            ack_o <= 1'b1;
            clr_o <= (17'h1 << FIDX[src_i]) | {1'b0, src_i==4'he, 2'b0, src_i==4'hc, 12'h0};
            depth <= depth + 1;
        end else if (depth > 0 && timer <= 0) begin
            ret_o <= 1'b1;
            depth <= depth - 1;
        end
    end
endmodule // flic_cpu_model

/* File: bench/tb_top.sv */
// Self-checking bench for the four-level interrupt controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
    localparam logic [15:0] VEC [15] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033,
        16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h006b, 16'h0023,
        16'h004b, 16'h0073};
    localparam int POS [15] = '{0, 5, 6, 1, 7, 11, 2, 8, 12, 3, 9, 13, 4, 10, 14};
    logic        clk_sys_i = 0, arst_n_i = 0, ext0_n = 1, ext1_n = 1, glob = 0, req, ack, ret;
    logic [3:0]  cap = '0, src, isr;
    logic [1:0]  lvl;
    logic [4:0]  code = 5'h1f;
    logic [5:0]  ev = '0;
    logic [14:0] en = '0, lo = '0, hi = '0;
    logic [15:0] cnt = '0, vec;
    logic [21:0] exp_v, q [$];
    logic [16:0] sw_set = '0, sw_clr = '0, cpu_clr, flags;
    logic [7:0]  seed = 8'h55;
    int          fails = 0, n_tests = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    flic_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .external_irq0_n_i(ext0_n),
        .external_irq1_n_i(ext1_n), .capture_input_i(cap), .timer0_overflow_i(ev[5]),
        .timer1_overflow_i(ev[4]), .uart_rx_done_i(ev[3]), .uart_tx_done_i(ev[2]),
        .serial_bus_status_load_i(ev[1]), .serial_bus_status_code_i(code),
        .adc_result_ready_i(ev[0]), .capture_timer_count_i(cnt),
        .compare_value_i(48'h0000ffff0000),
        .irq_enable_reg_a_i({glob, en[6:0]}), .irq_enable_reg_b_i(en[14:7]),
        .priority_low_reg_a_i({1'b0, lo[6:0]}), .priority_low_reg_b_i(lo[14:7]),
        .priority_high_reg_a_i({1'b0, hi[6:0]}), .priority_high_reg_b_i(hi[14:7]),
        .flag_sw_set_i(sw_set), .flag_sw_clr_i(sw_clr | cpu_clr), .irq_ack_i(ack),
        .irq_return_i(ret), .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl),
        .irq_source_o(src), .in_service_o(isr), .flags_o(flags));
    flic_cpu_model cpu (.clk_sys_i(clk_sys_i), .irq_req_i(req), .src_i(src), .ack_o(ack),
        .ret_o(ret), .clr_o(cpu_clr));
    // Compares each request that the CPU model takes with the oldest expected one.
    always @(negedge clk_sys_i) begin
        if (arst_n_i && req) begin
            exp_v = (q.size() > 0) ? q.pop_front() : 'x;
            `CHK("request", exp_v, {lvl, src, vec})
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic pulse(input logic [16:0] s, c, input int n);
        {sw_set, sw_clr} = {s, c};
        @(negedge clk_sys_i);
        {sw_set, sw_clr} = '0;
        repeat (n + 1) @(negedge clk_sys_i);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 3000 && (q.size() > 0 || isr !== 4'h0); i++) @(negedge clk_sys_i);
        if (i == 3000) begin
            fails++;
            complete_run();
        end
    endtask
    // Main sequence: flag sources, random levels, then enables and nesting.
    initial begin
        pulse(17'h0, 17'h0, 1);
        arst_n_i = 1'b1;
        pulse(17'h0, 17'h0, 1);
        {ext0_n, ext1_n, cap, ev, cnt} = {2'b00, 4'hf, 6'h3f, 16'hffff};
        pulse(17'h0, 17'h0, 0);
        {ev, cnt} = '0;
        pulse(17'h0, 17'h0, 19);
        `CHK("hw flags", 17'h1dfff, flags)
        ev[1] = 1'b1;
        code = 5'h08;
        pulse(17'h0, 17'h0, 0);
        ev[1] = 1'b0;
        `CHK("two-wire flag", 1'b1, flags[flic_pkg::F_I2C])
        pulse(17'h0, 17'h1ffff, 0);
        pulse(17'h1ffff, 17'h0, 0);
        `CHK("sw flags", 17'h1bfff, flags)
        pulse(17'h0, 17'h1ffff, 0);
        $display("test flag sources done");
        for (int k = 0; k < 30; k++) begin
            seed = lfsr(seed);
            {hi, lo} = {hi[13:0], lo, seed[0]};
        end
        {glob, en} = 16'hffff;
        for (int lv = 3; lv >= 0; lv--)
            for (int s = 0; s < 15; s++)
                if ({hi[POS[s]], lo[POS[s]]} == 2'(lv))
                    q.push_back({2'(lv), 4'(s), VEC[s]});
        ev[0] = 1'b1;
        pulse(17'h1ffff, 17'h0, 0);
        ev[0] = 1'b0;
        drain();
        $display("test priority order done");
        {glob, en, hi, lo} = {16'h7fff, 15'h0008, 15'h0};
        pulse(17'h00200, 17'h0, 4);
        `CHK("global off", 1'b0, req)
        {glob, en} = 16'hfffd;
        pulse(17'h0, 17'h0, 3);
        `CHK("source off", 1'b0, req)
        pulse(17'h0, 17'h00200, 0);
        q = '{{2'h0, 4'h6, 16'h0013}, {2'h2, 4'h9, 16'h001b}, {2'h0, 4'h0, 16'h0003}};
        pulse(17'h00002, 17'h0, 5);
        pulse(17'h00001, 17'h0, 4);
        `CHK("equal level", 1'b0, req)
        `CHK("in service", 4'h1, isr)
        pulse(17'h00400, 17'h0, 1);
        `CHK("preempted", 4'h5, isr)
        drain();
        $display("test nesting done");
        complete_run();
    end
endmodule // tb_top
